// ===== rtl/uv_pickup_pkg.sv
// Overview of operation
// - stage works on fundamental magnitudes refreshed every 5 ms update tick
// - quantity selector: line-line, phase-earth, channel 3, channel 4; default line-line
// - line or phase sets use three channels, two in two-line-two-aux mode
// - channel 4 always tracked; channel 3 only in two-line-two-aux mode
// - forced status normal/start/trip/blocked, effective only with forcing enabled
// - selector and forced status are static, untouched by setting group change
// - ratio of magnitude to threshold computed each update for three voltages
// - pick-up releases only when all voltages recover past 103 % threshold
// - one common threshold; any voltage falling below it picks up
// - threshold 0.00 to 120.00 % of nominal, 0.01 % step, default 60 %
// - pick-up and timing from active group, switched without stopping
// - block level 0.00 to 100.00 % of nominal, default 10 %, zero disables
// - voltage below non-zero block level marks network dead, no trip
// - dead-network block held until all voltages rise above threshold
// - expected operating time in 5 ms steps, inverse mode follows voltage
// - signed time remaining to trip shown while fault is timed
// - per-voltage ratio to threshold shown with 0.01 resolution
// - ratio of lowest voltage to threshold shown with per-voltage ratios
// - thresholds shown in primary volts, 0.1 V resolution, via scaling
// - external block active at pick-up gives blocked instead of start
// - zero delay trips together with start, instant stage
package uv_pickup_pkg;

	// ----------------------------------------------------------------
	// widths and scaling
	// ----------------------------------------------------------------
	localparam int MAG_W           = 16;
	localparam int TIME_W          = 20;
	localparam int RATIO_W         = 17;
	localparam int DIV_W           = 24;
	localparam int KDIAL_W         = 14;
	localparam int TICK_MS         = 5;
	localparam int K_STEP_MS       = 10;
	localparam int K_TO_TICKS      = K_STEP_MS / TICK_MS;
	localparam int RATIO_SCALE     = 100;
	localparam int RESET_RATIO_PCT = 103;
	localparam int PRIM_DIV        = 10000;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [MAG_W-1:0]   PICKUP_RST     = 16'h1770;
	localparam logic [MAG_W-1:0]   BLOCK_RST      = 16'h03E8;
	localparam logic [TIME_W-1:0]  DELAY_RST      = 20'h0_0008;
	localparam logic [KDIAL_W-1:0] KDIAL_RST      = 14'h0005;
	localparam logic [MAG_W-1:0]   PRIM_SCALE_RST = 16'h0064;
	localparam logic [MAG_W-1:0]   MAG_NONE       = 16'hFFFF;
	localparam logic [TIME_W-1:0]  TIME_MAX       = 20'hF_FFFF;
	localparam logic [RATIO_W-1:0] RATIO_MAX      = 17'h1_FFFF;
	localparam logic [4:0]         DIV_LAST       = 5'h17;
	localparam logic [1:0]         DIV_INVERSE_TIME_MODE       = 2'h3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL        = 12'h000;
	localparam logic [11:0] ADDR_STATUS      = 12'h004;
	localparam logic [11:0] ADDR_RATIO_A     = 12'h008;
	localparam logic [11:0] ADDR_RATIO_B     = 12'h00C;
	localparam logic [11:0] ADDR_RATIO_C     = 12'h010;
	localparam logic [11:0] ADDR_RATIO_MIN   = 12'h014;
	localparam logic [11:0] ADDR_EXPECTED    = 12'h018;
	localparam logic [11:0] ADDR_REMAIN      = 12'h01C;
	localparam logic [11:0] ADDR_PRIM_PICKUP = 12'h020;
	localparam logic [11:0] ADDR_PRIM_BLOCK  = 12'h024;
	localparam logic [11:0] ADDR_PRIM_SCALE  = 12'h028;
	localparam logic [6:0]  GRP_REGION       = 7'h02;
	localparam logic [1:0]  GRP_PICKUP       = 2'h0;
	localparam logic [1:0]  GRP_BLOCK        = 2'h1;
	localparam logic [1:0]  GRP_DELAY        = 2'h2;
	localparam logic [1:0]  GRP_TIMING       = 2'h3;
	localparam int          INVERSE_TIME_MODE_BIT         = 16;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {QTY_LINE, QTY_PHASE, QTY_AUX3, QTY_AUX4} quantity_e;
	typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} forced_e;
	typedef enum logic {DIV_IDLE, DIV_RUN} divPhase_e;

	typedef struct packed {
		logic [MAG_W-1:0] l12;
		logic [MAG_W-1:0] l23;
		logic [MAG_W-1:0] l31;
		logic [MAG_W-1:0] l1;
		logic [MAG_W-1:0] l2;
		logic [MAG_W-1:0] l3;
		logic [MAG_W-1:0] ch3;
		logic [MAG_W-1:0] ch4;
	} measIn_s;

	typedef struct packed {
		logic      group;
		logic      forceEn;
		forced_e   forced;
		logic      twoLineTwoAux;
		quantity_e qty;
	} ctrl_s;

	typedef struct packed {
		logic               inverse_time_mode;
		logic [KDIAL_W-1:0] kDial;
		logic [TIME_W-1:0]  delay;
		logic [MAG_W-1:0]   block;
		logic [MAG_W-1:0]   pickup;
	} groupSet_s;

	typedef struct packed {
		logic start;
		logic trip;
		logic blocked;
	} stageOut_s;

	typedef struct packed {
		ctrl_s                        ctrl;
		groupSet_s [1:0]              grp;
		logic [MAG_W-1:0]             primScale;
		logic                         syncA;
		logic                         syncB;
		logic [2:0][MAG_W-1:0]        snap;
		logic                         evalPend;
		logic                         pickup;
		logic                         deEnergized;
		stageOut_s                    stage;
		stageOut_s                    out;
		logic [TIME_W-1:0]            elapsed;
		logic [TIME_W-1:0]            expected;
		logic [3:0][RATIO_W-1:0]      ratio;
		divPhase_e                    divPhase;
		logic [1:0]                   divIdx;
		logic [4:0]                   divCnt;
		logic [DIV_W-1:0]             divRem;
		logic [DIV_W-1:0]             divQuo;
		logic [MAG_W-1:0]             divDen;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
	} state_s;

endpackage

// ===== rtl/uv_pickup_block.sv
module uv_pickup_block
	import uv_pickup_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire measIn_s     meas,
	input  wire logic        measTick,
	input  wire logic        extBlock,
	output stageOut_s        stageOut
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2*DIV_W-1:0] divStep(
		input logic [DIV_W-1:0] rem,
		input logic [DIV_W-1:0] quo,
		input logic [MAG_W-1:0] den
	);
		logic [DIV_W-1:0] sh;
		sh = {rem[DIV_W-2:0], quo[DIV_W-1]};
		if (sh >= DIV_W'(den)) begin
			return {sh - DIV_W'(den), quo[DIV_W-2:0], 1'b1};
		end
		return {sh, quo[DIV_W-2:0], 1'b0};
	endfunction

	// numerator and divisor for one of the four divisions of a tick
	function automatic logic [DIV_W+MAG_W-1:0] divOperands(
		input logic [1:0]            idx,
		input logic [2:0][MAG_W-1:0] snap,
		input groupSet_s             g,
		input logic [RATIO_W-1:0]    rMin
	);
		logic [31:0]      wide;
		logic [MAG_W-1:0] den;
		wide = 32'h0000_0000;
		den  = g.pickup;
		if (idx == DIV_INVERSE_TIME_MODE) begin
			wide = 32'(g.kDial) * K_TO_TICKS * RATIO_SCALE;
			den  = MAG_W'(RATIO_SCALE - 32'(rMin));
		end else begin
			wide = 32'(snap[idx]) * RATIO_SCALE;
		end
		return {wide[DIV_W-1:0], den};
	endfunction

	function automatic logic [RATIO_W-1:0] minOf(
		input logic [RATIO_W-1:0] a,
		input logic [RATIO_W-1:0] b
	);
		return (a < b) ? a : b;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_s                q;
	state_s                d;
	groupSet_s             g;
	logic [RATIO_W-1:0]    relLevel;
	logic                  anyBelow;
	logic                  allAboveRel;
	logic                  anyBelowBlk;
	logic                  allAbovePick;
	logic                  pickNext;
	logic                  deNext;
	logic                  access;
	logic                  ctrlWrite;
	logic [2*DIV_W-1:0]    stepOut;
	logic [DIV_W+MAG_W-1:0] ops;
	logic [TIME_W:0]       remain;
	logic [31:0]           rd;
	logic [31:0]           primPick;
	logic [31:0]           primBlk;
	logic [2:0][MAG_W-1:0] sel;

	// both groups start from the same settings
	localparam groupSet_s GRP_DEFAULT = '{inverse_time_mode: 1'b0, kDial: KDIAL_RST, delay: DELAY_RST,
		block: BLOCK_RST, pickup: PICKUP_RST};

	always_comb begin
		d       = q;
		g       = q.grp[q.ctrl.group];
		d.pready  = 1'b0;
		d.pslverr = 1'b0;
		d.evalPend = 1'b0;
		d.syncA = extBlock;
		d.syncB = q.syncA;
		access    = psel && penable && q.pready;
		ctrlWrite = access && pwrite && (paddr == ADDR_CTRL);
		remain    = {1'b0, q.expected} - {1'b0, q.elapsed};
		primPick  = (32'(g.pickup) * 32'(q.primScale)) / PRIM_DIV;
		primBlk   = (32'(g.block) * 32'(q.primScale)) / PRIM_DIV;
		stepOut   = '0;
		ops       = '0;

		// ------------------------------------------------------------
		// apb slave, one wait state
		// ------------------------------------------------------------
		rd = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL:        rd = 32'(q.ctrl);
			ADDR_STATUS:      rd = 32'({q.syncB, q.deEnergized, q.pickup, q.out});
			ADDR_RATIO_A:     rd = 32'(q.ratio[0]);
			ADDR_RATIO_B:     rd = 32'(q.ratio[1]);
			ADDR_RATIO_C:     rd = 32'(q.ratio[2]);
			ADDR_RATIO_MIN:   rd = 32'(q.ratio[3]);
			ADDR_EXPECTED:    rd = 32'(q.expected);
			ADDR_REMAIN:      rd = {{(32-TIME_W-1){remain[TIME_W]}}, remain};
			ADDR_PRIM_PICKUP: rd = primPick;
			ADDR_PRIM_BLOCK:  rd = primBlk;
			ADDR_PRIM_SCALE:  rd = 32'(q.primScale);
			default: begin
				if (paddr[11:5] == GRP_REGION) begin
					case (paddr[3:2])
						GRP_PICKUP: rd = 32'(q.grp[paddr[4]].pickup);
						GRP_BLOCK:  rd = 32'(q.grp[paddr[4]].block);
						GRP_DELAY:  rd = 32'(q.grp[paddr[4]].delay);
						default:    rd = 32'({q.grp[paddr[4]].inverse_time_mode, 2'b00, q.grp[paddr[4]].kDial});
					endcase
				end
			end
		endcase
		if (psel && penable && !q.pready) begin
			d.pready  = 1'b1;
			d.prdata  = rd;
			d.pslverr = !((paddr <= ADDR_PRIM_SCALE && paddr[1:0] == 2'b00)
				|| (paddr[11:5] == GRP_REGION && paddr[1:0] == 2'b00));
		end
		if (access && pwrite) begin
			case (paddr)
				ADDR_CTRL:       d.ctrl = ctrl_s'(pwdata[$bits(ctrl_s)-1:0]);
				ADDR_PRIM_SCALE: d.primScale = pwdata[MAG_W-1:0];
				default: begin
					if (paddr[11:5] == GRP_REGION) begin
						case (paddr[3:2])
							GRP_PICKUP: d.grp[paddr[4]].pickup = pwdata[MAG_W-1:0];
							GRP_BLOCK:  d.grp[paddr[4]].block  = pwdata[MAG_W-1:0];
							GRP_DELAY:  d.grp[paddr[4]].delay  = pwdata[TIME_W-1:0];
							default: begin
								d.grp[paddr[4]].kDial = pwdata[KDIAL_W-1:0];
								d.grp[paddr[4]].inverse_time_mode  = pwdata[INVERSE_TIME_MODE_BIT];
							end
						endcase
					end
				end
			endcase
		end

		// ------------------------------------------------------------
		// input selection and snapshot
		// ------------------------------------------------------------
		// two-channel sets repeat the second channel
		case (q.ctrl.qty)
			QTY_LINE: sel = q.ctrl.twoLineTwoAux ? {meas.l23, meas.l23, meas.l12}
				: {meas.l31, meas.l23, meas.l12};
			QTY_PHASE: sel = q.ctrl.twoLineTwoAux ? {meas.l2, meas.l2, meas.l1}
				: {meas.l3, meas.l2, meas.l1};
			// channel 3 only in two-line-two-aux mode
			QTY_AUX3: sel = q.ctrl.twoLineTwoAux ? {3{meas.ch3}} : {3{MAG_NONE}};
			default:  sel = {3{meas.ch4}};
		endcase
		if (measTick) begin
			d.snap     = sel;
			d.evalPend = 1'b1;
		end

		// ------------------------------------------------------------
		// comparisons on the snapshot
		// ------------------------------------------------------------
		relLevel     = RATIO_W'((32'(g.pickup) * RESET_RATIO_PCT) / RATIO_SCALE);
		anyBelow     = 1'b0;
		allAboveRel  = 1'b1;
		anyBelowBlk  = 1'b0;
		allAbovePick = 1'b1;
		for (int i = 0; i < 3; i++) begin
			anyBelow     = anyBelow || (q.snap[i] < g.pickup);
			allAboveRel  = allAboveRel && (RATIO_W'(q.snap[i]) >= relLevel);
			anyBelowBlk  = anyBelowBlk || (q.snap[i] < g.block);
			allAbovePick = allAbovePick && (q.snap[i] > g.pickup);
		end
		pickNext = q.pickup ? !allAboveRel : anyBelow;
		if (g.block == '0) begin
			deNext = 1'b0;
		end else if (anyBelowBlk) begin
			deNext = 1'b1;
		end else begin
			deNext = allAbovePick ? 1'b0 : q.deEnergized;
		end

		// group switch takes effect at once
		if (!g.inverse_time_mode) begin
			d.expected = g.delay;
		end

		if (q.evalPend) begin
			d.pickup      = pickNext;
			d.deEnergized = deNext;
			if (!pickNext) begin
				d.stage   = '0;
				d.elapsed = '0;
			end else if (q.syncB || q.stage.blocked) begin
				d.stage   = '{start: 1'b0, trip: 1'b0, blocked: 1'b1};
				d.elapsed = '0;
			end else begin
				d.stage.start = 1'b1;
				if (q.stage.start && q.elapsed != TIME_MAX) begin
					d.elapsed = q.elapsed + 1'b1;
				end
				// zero delay trips with start, never when dead
				d.stage.trip = (d.elapsed >= d.expected) && !deNext;
			end
			ops        = divOperands(2'h0, q.snap, g, q.ratio[3]);
			d.divPhase = DIV_RUN;
			d.divIdx   = 2'h0;
			d.divCnt   = '0;
			d.divRem   = '0;
			d.divQuo   = ops[DIV_W+MAG_W-1:MAG_W];
			d.divDen   = ops[MAG_W-1:0];
		end else begin
			case (q.divPhase)
				DIV_RUN: begin
					stepOut  = divStep(q.divRem, q.divQuo, q.divDen);
					d.divRem = stepOut[2*DIV_W-1:DIV_W];
					d.divQuo = stepOut[DIV_W-1:0];
					d.divCnt = q.divCnt + 1'b1;
					if (q.divCnt == DIV_LAST) begin
						if (q.divIdx == DIV_INVERSE_TIME_MODE) begin
							if (g.inverse_time_mode) begin
								d.expected = (q.ratio[3] >= RATIO_W'(RATIO_SCALE)
									|| d.divQuo > DIV_W'(TIME_MAX)) ? TIME_MAX
									: d.divQuo[TIME_W-1:0];
							end
							d.divPhase = DIV_IDLE;
						end else begin
							d.ratio[q.divIdx] = (d.divQuo > DIV_W'(RATIO_MAX)) ? RATIO_MAX
								: d.divQuo[RATIO_W-1:0];
							if (q.divIdx == 2'h2) begin
								d.ratio[3] = minOf(minOf(d.ratio[0], d.ratio[1]), d.ratio[2]);
							end
							ops      = divOperands(q.divIdx + 1'b1, q.snap, g, d.ratio[3]);
							d.divIdx = q.divIdx + 1'b1;
							d.divCnt = '0;
							d.divRem = '0;
							d.divQuo = ops[DIV_W+MAG_W-1:MAG_W];
							d.divDen = ops[MAG_W-1:0];
						end
					end
				end
				default: d.divPhase = DIV_IDLE;
			endcase
		end

		if (q.ctrl.forceEn && q.ctrl.forced != FORCE_NORMAL) begin
			d.out = '{start: q.ctrl.forced == FORCE_START, trip: q.ctrl.forced == FORCE_TRIP,
				blocked: q.ctrl.forced == FORCE_BLOCKED};
		end else begin
			d.out = d.stage;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			q               <= '0;
			q.ctrl.qty      <= QTY_LINE;
			q.ctrl.forced   <= FORCE_NORMAL;
			q.grp           <= {2{GRP_DEFAULT}};
			q.primScale     <= PRIM_SCALE_RST;
			q.divPhase      <= DIV_IDLE;
		end else begin
			q <= d;
		end
	end

	assign prdata   = q.prdata;
	assign pready   = q.pready;
	assign pslverr  = q.pslverr;
	assign stageOut = q.out;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_tickSnap;
		measTick |=> q.evalPend && q.snap == $past(sel);
	endproperty
	a_tickSnap: assert property (p_tickSnap) else $error("tick snapshot missing");

	property p_holdPickup;
		q.evalPend && q.pickup && !allAboveRel |=> q.pickup;
	endproperty
	a_holdPickup: assert property (p_holdPickup) else $error("pickup released early");

	property p_pickupSet;
		q.evalPend && anyBelow |=> q.pickup;
	endproperty
	a_pickupSet: assert property (p_pickupSet) else $error("pickup not set");

	property p_deadNoTrip;
		q.deEnergized |-> !q.stage.trip;
	endproperty
	a_deadNoTrip: assert property (p_deadNoTrip) else $error("trip while dead");

	property p_blockOff;
		q.evalPend && g.block == '0 |=> !q.deEnergized;
	endproperty
	a_blockOff: assert property (p_blockOff) else $error("block level zero yet dead");

	property p_instant;
		q.evalPend && pickNext && !q.syncB && !q.stage.blocked && !deNext
			&& !g.inverse_time_mode && g.delay == '0 |=> q.stage.start && q.stage.trip;
	endproperty
	a_instant: assert property (p_instant) else $error("instant trip missing");

	property p_extBlock;
		q.evalPend && pickNext && q.syncB |=> q.stage.blocked && !q.stage.start;
	endproperty
	a_extBlock: assert property (p_extBlock) else $error("blocked not raised");

	property p_forceTrip;
		q.ctrl.forceEn && q.ctrl.forced == FORCE_TRIP ##1 $stable(q.ctrl)
			|-> stageOut.trip && !stageOut.start;
	endproperty
	a_forceTrip: assert property (p_forceTrip) else $error("forced trip ignored");

	property p_forceOff;
		!q.ctrl.forceEn |=> stageOut == q.stage;
	endproperty
	a_forceOff: assert property (p_forceOff) else $error("forcing acted while disabled");

	property p_ctrlStatic;
		!ctrlWrite |=> $stable(q.ctrl);
	endproperty
	a_ctrlStatic: assert property (p_ctrlStatic) else $error("static settings moved");

	property p_ratioDone;
		q.evalPend |-> ##[1:100] q.divPhase == DIV_IDLE;
	endproperty
	a_ratioDone: assert property (p_ratioDone) else $error("ratios not finished");

	c_trip:    cover property (q.stage.trip && !q.deEnergized);
	c_blocked: cover property (q.stage.blocked);
	c_dead:    cover property (q.deEnergized && q.pickup);
	c_forced:  cover property (q.ctrl.forceEn && q.ctrl.forced == FORCE_BLOCKED);

endmodule // uv_pickup_block

// ===== tb/uv_meas_source.sv
module uv_meas_source
	import uv_pickup_pkg::*;
#(
	parameter int GAP = 200
)
(
	input  wire logic    clk,
	input  wire logic    rstn,
	input  wire measIn_s vals,
	output measIn_s      meas,
	output logic         measTick
);
	timeunit 1ns;
	timeprecision 1ps;

	int      cnt;
	measIn_s held;

	// ----------------------------------------------------------------
	// update cadence
	// ----------------------------------------------------------------
	// one update per period
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt      <= 0;
			measTick <= 1'b0;
		end else begin
			measTick <= (cnt == GAP - 1);
			cnt      <= (cnt == GAP - 1) ? 0 : cnt + 1;
		end
		held <= vals;
	end

	// valid only with tick
	// inverted between ticks so a late sample cannot pass by luck
	assign meas = measTick ? held : ~held;
endmodule // uv_meas_source

// ===== tb/uv_pickup_block_tb_top.sv
module uv_pickup_block_tb_top
	import uv_pickup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        rstn, psel, penable, pwrite, pready, pslverr, measTick, extBlock, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	measIn_s     vals, meas, tmp;
	stageOut_s   stageOut;
	int          err_count = 0;
	int          comparisons = 0;
	logic [6:0]  qc [6] = '{7'h01, 7'h03, 7'h02, 7'h06, 7'h04, 7'h04};
	int          qi [6] = '{3, 7, 6, 6, 2, 1};
	logic        qe [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	always #2 clk = ~clk;

	uv_pickup_block u_uv_pickup_block (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .meas(meas), .measTick(measTick), .extBlock(extBlock),
		.stageOut(stageOut));
	uv_meas_source u_uv_meas_source (.clk(clk), .rstn(rstn), .vals(vals), .meas(meas),
		.measTick(measTick));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) begin
			err_count++;
			conclude();
		end
		rdv = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdv, exp);
	endtask

	// ratios need about 100 clocks after the tick
	task automatic ticks(input int k);
		int w;
		repeat (k) begin
			w = 0;
			@(posedge clk);
			while (measTick !== 1'b1 && w < 1000) begin
				@(posedge clk);
				w++;
			end
			if (w >= 1000) begin
				err_count++;
				conclude();
			end
		end
		repeat (120) @(posedge clk);
	endtask

	task automatic stg(input logic [15:0] l12, input logic [2:0] exp);
		vals.l12 <= l12;
		ticks(2);
		chk({29'h0, stageOut}, {29'h0, exp});
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		extBlock = 1'b0;
		vals = {8{16'h2EE0}};
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rdc(ADDR_CTRL, 32'h0000_0000);
		rdc(12'h040, 32'h0000_1770);
		rdc(12'h044, 32'h0000_03E8);
		rdc(ADDR_PRIM_PICKUP, 32'h0000_003C);
		rdc(ADDR_PRIM_BLOCK, 32'h0000_000A);
		rdc(12'h0FC, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		vals.l23 <= 16'h2328;
		vals.l31 <= 16'h1D4C;
		ticks(2);
		rdc(ADDR_RATIO_A, 32'h0000_00C8);
		rdc(ADDR_RATIO_B, 32'h0000_0096);
		rdc(ADDR_RATIO_C, 32'h0000_007D);
		rdc(ADDR_RATIO_MIN, 32'h0000_007D);
		vals <= {8{16'h2EE0}};
		stg(16'h1518, 3'b100);
		rdc(ADDR_EXPECTED, 32'h0000_0008);
		rdc(ADDR_REMAIN, 32'h0000_0007);
		ticks(5);
		chk({31'h0, stageOut.trip}, 32'h0000_0000);
		ticks(5);
		chk({31'h0, stageOut.trip}, 32'h0000_0001);
		stg(16'h1806, 3'b110);
		stg(16'h189C, 3'b000);
		apb(1'b1, 12'h048, 32'h0000_0000);
		stg(16'h1518, 3'b110);
		stg(16'h2EE0, 3'b000);
		stg(16'h01F4, 3'b100);
		rdc(ADDR_STATUS, 32'h0000_001C);
		stg(16'h1388, 3'b100);
		stg(16'h2EE0, 3'b000);
		stg(16'h1388, 3'b110);
		stg(16'h2EE0, 3'b000);
		apb(1'b1, 12'h044, 32'h0000_0000);
		stg(16'h01F4, 3'b110);
		stg(16'h2EE0, 3'b000);
		apb(1'b1, 12'h044, 32'h0000_03E8);
		extBlock <= 1'b1;
		stg(16'h1388, 3'b001);
		stg(16'h2EE0, 3'b000);
		extBlock <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h0000_0008);
		stg(16'h2EE0, 3'b000);
		for (int f = 1; f < 4; f++) begin
			apb(1'b1, ADDR_CTRL, 32'h0000_0020 | (f << 3));
			stg(16'h2EE0, 3'b100 >> (f - 1));
		end
		apb(1'b1, ADDR_CTRL, 32'h0000_0070);
		stg(16'h2EE0, 3'b010);
		rdc(ADDR_CTRL, 32'h0000_0070);
		apb(1'b1, 12'h050, 32'h0000_2328);
		apb(1'b1, ADDR_CTRL, 32'h0000_0040);
		vals <= {8{16'h1FA4}};
		ticks(2);
		chk({31'h0, stageOut.start}, 32'h0000_0001);
		rdc(ADDR_RATIO_A, 32'h0000_005A);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		stg(16'h1FA4, 3'b000);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, ADDR_CTRL, {25'h0, qc[i]});
			tmp = {8{16'h2EE0}};
			tmp[(7 - qi[i]) * 16 +: 16] = 16'h1388;
			vals <= tmp;
			ticks(2);
			chk({31'h0, stageOut.start}, {31'h0, qe[i]});
			vals <= {8{16'h2EE0}};
			ticks(2);
		end
		conclude();
	end
endmodule // uv_pickup_block_tb_top
